// ===== include/ctci_pkg.sv
// Purpose: shared constants and types for cell test control and inhibit
// Assumes: 100 MHz sys_clk, 32-bit plain register port
// Notes:   voltages in 0.1 mV, current in 0.1 uA, times in seconds
package ctci_pkg;
   localparam int unsigned CLK_HZ    = 100_000_000;
   localparam int unsigned SEC_S     = 1;
   localparam int unsigned SEC_CYC   = SEC_S * CLK_HZ;
   localparam int unsigned BLINK_MS  = 500;
   localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
   localparam int unsigned PROBE_NS  = 160;
   localparam int unsigned PROBE_CYC = PROBE_NS / (1_000_000_000 / CLK_HZ);

   localparam int unsigned NCH = 32;

   // register offsets
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_CFG   = 8'h04;
   localparam logic [7:0] A_OVP   = 8'h08;
   localparam logic [7:0] A_UVP   = 8'h0c;
   localparam logic [7:0] A_OCP   = 8'h10;
   localparam logic [7:0] A_TINT  = 8'h14;
   localparam logic [7:0] A_CHAN  = 8'h18;
   localparam logic [7:0] A_STAT  = 8'h1c;
   localparam logic [7:0] A_UPD   = 8'h20;
   localparam logic [7:0] A_MAXH  = 8'h24;
   localparam logic [7:0] A_QSEL  = 8'h28;
   localparam logic [7:0] A_QOVP  = 8'h2c;
   localparam logic [7:0] A_QUVP  = 8'h30;
   localparam logic [7:0] A_QOCP  = 8'h34;
   localparam logic [7:0] A_QTINT = 8'h38;
   localparam logic [7:0] A_RES   = 8'h3c;
   localparam logic [7:0] A_PRES  = 8'h40;

   // control bits (write pulses)
   localparam int unsigned C_OCV   = 0;
   localparam int unsigned C_PROBE = 1;
   localparam int unsigned C_CLR   = 2;
   localparam int unsigned C_STOP  = 3;
   // config fields
   localparam int unsigned F_MODE  = 0;
   localparam int unsigned F_LOC   = 2;

   // parameter limits
   localparam logic [15:0]        V_MIN    = 16'd5000;
   localparam logic [15:0]        V_MAX    = 16'd45000;
   localparam logic signed [31:0] I_MIN    = -32'sd100000;
   localparam logic signed [31:0] I_MAX    = 32'sd100000;
   localparam logic [8:0]         T_MIN    = 9'd1;
   localparam logic [8:0]         T_GENMAX = 9'd250;
   localparam logic [8:0]         T_OCVMAX = 9'd256;
   localparam logic [8:0]         T_DEF    = 9'd1;
   localparam logic [8:0]         UPD_MIN  = 9'd4;
   localparam logic [4:0]         HRS_PER  = 5'd24;

   // not-a-number marker, single precision form of 9.91e37
   localparam logic [31:0] NAN_MARK = 32'h7e951b72;

   typedef enum logic [1:0] {INH_OFF, INH_LIVE, INH_LATCH} ctci_inh_t;
   typedef enum logic [1:0] {ST_IDLE, ST_OCV, ST_PROBE} ctci_st_t;

   typedef struct packed {
      logic [15:0]        ovp;
      logic [15:0]        uvp;
      logic signed [31:0] ocp;
      logic [8:0]         tint;
   } ctci_par_t;
endpackage

// ===== hdl/ctci_chk.sv
// Purpose: range check and derived timing of a test request
// Assumes: inputs stable from the same clock domain
// Notes:   purely combinational
`timescale 1ns/1ps
module ctci_chk (
   input  ctci_pkg::ctci_par_t par,
   input  wire logic           is_ocv,
   output logic                ok,
   output logic [8:0]          upd_s,
   output logic [12:0]         max_h
);
   logic [8:0] tmax;
   logic       v_ok;
   logic       i_ok;

   always_comb begin
      tmax = is_ocv ? ctci_pkg::T_OCVMAX : ctci_pkg::T_GENMAX;
      v_ok = (par.ovp >= ctci_pkg::V_MIN) && (par.ovp <= ctci_pkg::V_MAX) &&
             (par.uvp >= ctci_pkg::V_MIN) && (par.uvp <= ctci_pkg::V_MAX);
      i_ok = (par.ocp >= ctci_pkg::I_MIN) && (par.ocp <= ctci_pkg::I_MAX);
      ok   = v_ok && i_ok && (par.tint >= ctci_pkg::T_MIN) && (par.tint <= tmax);
   end

   // smallest power of two not below the interval, floor of four, ceiling of 256
   always_comb begin
      upd_s = ctci_pkg::T_OCVMAX;
      for (int i = 8; i >= 2; i--) begin
         if (par.tint <= 9'(1 << i)) begin
            upd_s = 9'(1 << i);
         end
      end
      if (upd_s < ctci_pkg::UPD_MIN) begin
         upd_s = ctci_pkg::UPD_MIN;
      end
   end

   // longest test in hours is the interval times 24
   assign max_h = 13'(par.tint * ctci_pkg::HRS_PER);
endmodule

// ===== hdl/ctci_top.sv
// Purpose: test session control, presence check, inhibit and indicators
// Assumes: inhibit_in and cell_sense are pins; meas_* and prot_trip are on sys_clk
// Notes:   one test at a time; stop command ends an open-cell test
`timescale 1ns/1ps
module ctci_top #(
   parameter int unsigned SEC_CYC   = ctci_pkg::SEC_CYC,
   parameter int unsigned BLINK_CYC = ctci_pkg::BLINK_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [31:0] rdata,
   input  wire logic        inhibit_in,
   input  wire logic [31:0] cell_sense,
   input  wire logic        meas_valid,
   input  wire logic [4:0]  meas_ch,
   input  wire logic [31:0] meas_value,
   input  wire logic        prot_trip,
   output logic [31:0]      chan_connect,
   output logic             error_led,
   output logic             locate_led
);
   ctci_pkg::ctci_par_t par_r;
   ctci_pkg::ctci_par_t stored_r [ctci_pkg::NCH];
   ctci_pkg::ctci_inh_t mode_r;
   ctci_pkg::ctci_st_t  st_r;
   logic [31:0] chan_r, group_r, pres_r, rdata_r, conn_r;
   logic [31:0] res_r [ctci_pkg::NCH];
   logic [31:0] sense_s1_r, sense_s2_r;
   logic [4:0]  qsel_r;
   logic        loc_r, loc_led_r, err_r, inh_lat_r, prot_r, rej_r;
   logic        inh_s1_r, inh_s2_r;
   logic        ocv_rdy_r, prb_rdy_r;
   logic [31:0] sec_cnt_r, blink_cnt_r;
   logic [8:0]  secs_r, upd_r;
   logic [7:0]  prb_cnt_r;
   logic        ctrl_wr, go_ocv, go_prb, clr, stop, start_req, start_ok;
   logic        chk_ok, inh_act, disc;
   logic [8:0]  upd_s;
   logic [12:0] max_h;

   assign ctrl_wr   = wr && (addr == ctci_pkg::A_CTRL);
   assign go_ocv    = ctrl_wr && wdata[ctci_pkg::C_OCV];
   assign go_prb    = ctrl_wr && wdata[ctci_pkg::C_PROBE] && !go_ocv;
   assign clr       = ctrl_wr && wdata[ctci_pkg::C_CLR];
   assign stop      = ctrl_wr && wdata[ctci_pkg::C_STOP];
   assign start_req = go_ocv || go_prb;
   // a start while busy, or an open-cell start with bad values, never starts
   assign start_ok  = start_req && (st_r == ctci_pkg::ST_IDLE) && (chan_r != '0) &&
                      (go_prb || chk_ok);

   ctci_chk u_chk (
      .par    (par_r),
      .is_ocv (1'b1),
      .ok     (chk_ok),
      .upd_s  (upd_s),
      .max_h  (max_h)
   );

   // staged parameters; a zero interval falls back to the default
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         par_r.ovp  <= ctci_pkg::V_MIN;
         par_r.uvp  <= ctci_pkg::V_MIN;
         par_r.ocp  <= '0;
         par_r.tint <= ctci_pkg::T_DEF;
         chan_r     <= '0;
         mode_r     <= ctci_pkg::INH_OFF;
         loc_r      <= 1'b0;
         qsel_r     <= '0;
      end else if (wr) begin
         case (addr)
            ctci_pkg::A_OVP:  par_r.ovp <= wdata[15:0];
            ctci_pkg::A_UVP:  par_r.uvp <= wdata[15:0];
            ctci_pkg::A_OCP:  par_r.ocp <= wdata;
            ctci_pkg::A_TINT: par_r.tint <= (wdata[8:0] == '0) ? ctci_pkg::T_DEF
                                                              : wdata[8:0];
            ctci_pkg::A_CHAN: chan_r <= wdata;
            ctci_pkg::A_QSEL: qsel_r <= wdata[4:0];
            ctci_pkg::A_CFG: begin
               mode_r <= (wdata[1:0] == 2'h1) ? ctci_pkg::INH_LIVE :
                         (wdata[1:0] == 2'h2) ? ctci_pkg::INH_LATCH : ctci_pkg::INH_OFF;
               loc_r  <= wdata[ctci_pkg::F_LOC];
            end
            default: ;
         endcase
      end
   end

   // parameters stored per channel only on an accepted open-cell start
   generate
      for (genvar g = 0; g < ctci_pkg::NCH; g++) begin : g_ch
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               stored_r[g] <= '0;
               res_r[g]    <= ctci_pkg::NAN_MARK;
            end else begin
               if (start_ok && go_ocv && chan_r[g]) begin
                  stored_r[g] <= par_r;
               end
               if (st_r == ctci_pkg::ST_OCV && meas_valid && meas_ch == 5'(g)) begin
                  res_r[g] <= meas_value;
               end
            end
         end
      end
   endgenerate

   // session sequencer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r      <= ctci_pkg::ST_IDLE;
         group_r   <= '0;
         upd_r     <= ctci_pkg::UPD_MIN;
         prb_cnt_r <= '0;
      end else begin
         case (st_r)
            ctci_pkg::ST_IDLE: begin
               if (start_ok) begin
                  group_r   <= chan_r;
                  upd_r     <= upd_s;
                  prb_cnt_r <= '0;
                  st_r      <= go_ocv ? ctci_pkg::ST_OCV : ctci_pkg::ST_PROBE;
               end
            end
            ctci_pkg::ST_OCV: begin
               if (stop) begin
                  st_r <= ctci_pkg::ST_IDLE;
               end
            end
            ctci_pkg::ST_PROBE: begin
               prb_cnt_r <= prb_cnt_r + 8'h01;
               if (prb_cnt_r == 8'(ctci_pkg::PROBE_CYC - 1)) begin
                  st_r <= ctci_pkg::ST_IDLE;
               end
            end
            default: st_r <= ctci_pkg::ST_IDLE;
         endcase
      end
   end

   // seconds timer for the open-cell session
   always_ff @(posedge sys_clk) begin
      if (rst || st_r != ctci_pkg::ST_OCV) begin
         sec_cnt_r <= '0;
         secs_r    <= '0;
      end else if (sec_cnt_r == 32'(SEC_CYC - 1)) begin
         sec_cnt_r <= '0;
         if (secs_r != upd_r) begin
            secs_r <= secs_r + 9'h001;
         end
      end else begin
         sec_cnt_r <= sec_cnt_r + 32'h1;
      end
   end

   // ready flags drop on any new start, so a probe session hides open-cell state
   always_ff @(posedge sys_clk) begin
      if (rst || start_ok) begin
         ocv_rdy_r <= 1'b0;
         prb_rdy_r <= 1'b0;
      end else begin
         if (st_r == ctci_pkg::ST_OCV && secs_r == upd_r) begin
            ocv_rdy_r <= 1'b1;
         end
         if (st_r == ctci_pkg::ST_PROBE && prb_cnt_r == 8'(ctci_pkg::PROBE_CYC - 1)) begin
            prb_rdy_r <= 1'b1;
         end
      end
   end

   // cell sense pins are asynchronous, two flops before use
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sense_s1_r <= '0;
         sense_s2_r <= '0;
         pres_r     <= '0;
      end else begin
         sense_s1_r <= cell_sense;
         sense_s2_r <= sense_s1_r;
         if (st_r == ctci_pkg::ST_PROBE && prb_cnt_r == 8'(ctci_pkg::PROBE_CYC - 1)) begin
            pres_r <= sense_s2_r & group_r;
         end
      end
   end

   // inhibit synchronizer
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         inh_s1_r <= 1'b0;
         inh_s2_r <= 1'b0;
      end else begin
         inh_s1_r <= inhibit_in;
         inh_s2_r <= inh_s1_r;
      end
   end

   assign inh_act = inh_s2_r && (mode_r != ctci_pkg::INH_OFF);
   assign disc    = inh_lat_r || (inh_s2_r && mode_r == ctci_pkg::INH_LIVE) ||
                    (inh_s2_r && mode_r == ctci_pkg::INH_LATCH);

   // sticky faults; a fresh inhibit or trip wins over a clear
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         inh_lat_r <= 1'b0;
         err_r     <= 1'b0;
         prot_r    <= 1'b0;
         rej_r     <= 1'b0;
      end else begin
         if (inh_s2_r && mode_r == ctci_pkg::INH_LATCH) begin
            inh_lat_r <= 1'b1;
         end else if (clr) begin
            inh_lat_r <= 1'b0;
         end
         if (inh_act) begin
            err_r <= 1'b1;
         end else if (clr) begin
            err_r <= 1'b0;
         end
         if (prot_trip) begin
            prot_r <= 1'b1;
         end else if (clr) begin
            prot_r <= 1'b0;
         end
         if (start_req && !start_ok) begin
            rej_r <= 1'b1;
         end else if (clr) begin
            rej_r <= 1'b0;
         end
      end
   end

   // channel connections: session group less any inhibit disconnect
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         conn_r <= '0;
      end else begin
         conn_r <= (st_r == ctci_pkg::ST_IDLE || disc) ? '0 : group_r;
      end
   end

   // locate blink; the counter rests at its end while off so the first cycle on lights it,
   // and every later toggle waits a full period, so on and off times match
   always_ff @(posedge sys_clk) begin
      if (rst || !loc_r) begin
         blink_cnt_r <= 32'(BLINK_CYC - 1);
         loc_led_r   <= 1'b0;
      end else if (blink_cnt_r == 32'(BLINK_CYC - 1)) begin
         blink_cnt_r <= '0;
         loc_led_r   <= !loc_led_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h1;
      end
   end

   // read port, data valid the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (rd) begin
         case (addr)
            ctci_pkg::A_CFG:   rdata_r <= {29'h0, loc_r, mode_r};
            ctci_pkg::A_OVP:   rdata_r <= {16'h0, par_r.ovp};
            ctci_pkg::A_UVP:   rdata_r <= {16'h0, par_r.uvp};
            ctci_pkg::A_OCP:   rdata_r <= par_r.ocp;
            ctci_pkg::A_TINT:  rdata_r <= {23'h0, par_r.tint};
            ctci_pkg::A_CHAN:  rdata_r <= chan_r;
            ctci_pkg::A_STAT:  rdata_r <= {22'h0, st_r, rej_r, prot_r, err_r, inh_lat_r,
                                           disc, 1'b0, prb_rdy_r, ocv_rdy_r};
            ctci_pkg::A_UPD:   rdata_r <= {23'h0, upd_s};
            ctci_pkg::A_MAXH:  rdata_r <= {19'h0, max_h};
            ctci_pkg::A_QSEL:  rdata_r <= {27'h0, qsel_r};
            ctci_pkg::A_QOVP:  rdata_r <= {16'h0, stored_r[qsel_r].ovp};
            ctci_pkg::A_QUVP:  rdata_r <= {16'h0, stored_r[qsel_r].uvp};
            ctci_pkg::A_QOCP:  rdata_r <= stored_r[qsel_r].ocp;
            ctci_pkg::A_QTINT: rdata_r <= {23'h0, stored_r[qsel_r].tint};
            ctci_pkg::A_RES:   rdata_r <= group_r[qsel_r] ? res_r[qsel_r]
                                                          : ctci_pkg::NAN_MARK;
            ctci_pkg::A_PRES:  rdata_r <= pres_r;
            default:           rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign rdata        = rdata_r;
   assign chan_connect = conn_r;
   assign error_led    = err_r;
   assign locate_led   = loc_led_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_lat_inh;
      inh_s2_r && mode_r == ctci_pkg::INH_LATCH;
   endsequence

   // a clear right after release may legally reconnect, so it leaves the window
   a_latch_holds_off: assert property (
      s_lat_inh ##1 (!inh_s2_r && !clr) [*2] |-> ##1 conn_r == '0)
      else $error("latched inhibit released without clear");
   a_live_reconnect: assert property (mode_r == ctci_pkg::INH_LIVE && !inh_lat_r &&
      !inh_s2_r && st_r == ctci_pkg::ST_OCV |=> conn_r == group_r)
      else $error("live inhibit did not reconnect");
   a_off_ignores: assert property (mode_r == ctci_pkg::INH_OFF && !inh_lat_r &&
      st_r == ctci_pkg::ST_OCV |=> conn_r == group_r)
      else $error("inhibit acted in off mode");
   a_err_on_inhibit: assert property (inh_act |=> err_r)
      else $error("error indicator missed inhibit");
   a_clear_all: assert property (clr && !inh_act && !prot_trip
      && !(start_req && !start_ok) && !(inh_s2_r && mode_r == ctci_pkg::INH_LATCH)
      |=> !err_r && !inh_lat_r && !prot_r && !rej_r)
      else $error("fault clear left a fault set");
   a_one_session: assert property (st_r != ctci_pkg::ST_IDLE && start_req |=>
      $stable(group_r) && rej_r)
      else $error("second session started");
   // a busy session may still end on its own in that cycle; only idle must stay idle
   a_reject_keeps: assert property (start_req && !start_ok |=>
      ($past(st_r) != ctci_pkg::ST_IDLE || st_r == ctci_pkg::ST_IDLE)
      && $stable(stored_r[0]) && $stable(group_r))
      else $error("rejected start changed state");
   // staged intervals beyond the legal range are refused at start, not derived
   a_upd_pow2: assert property (par_r.tint <= ctci_pkg::T_OCVMAX |->
      upd_s >= ctci_pkg::UPD_MIN && upd_s >= par_r.tint && (upd_s & (upd_s - 9'h001)) == '0
      && (upd_s == ctci_pkg::UPD_MIN || (upd_s >> 1) < par_r.tint))
      else $error("update period not a power of two");
   a_maxh_scale: assert property (max_h == 13'(par_r.tint * ctci_pkg::HRS_PER))
      else $error("maximum hours wrong");
   // the check spends the full probe count of sixteen cycles before reporting
   a_probe_ready: assert property (go_prb && start_ok |=> !prb_rdy_r
      ##16 (st_r == ctci_pkg::ST_IDLE && prb_rdy_r))
      else $error("presence check ready late");
   a_ocv_ready_type: assert property (st_r == ctci_pkg::ST_PROBE |-> !ocv_rdy_r)
      else $error("open-cell ready during other test");
   a_nan_outside: assert property (rd && addr == ctci_pkg::A_RES && !group_r[qsel_r]
      |=> rdata == ctci_pkg::NAN_MARK)
      else $error("outside channel not marked");
   a_locate_off: assert property (!loc_r |=> !locate_led)
      else $error("indicator blinks while locate off");
endmodule

// ===== verification/ctci_far_model.sv
// Purpose: far-side pins: inhibit source, cell sense and measurement front end
// Assumes: driven by bench tasks, every change lands just after sys_clk rises
// Notes:   idle measurement lines show the inverse of their last word
`timescale 1ns/1ps
module ctci_far_model (
   input  wire logic        sys_clk,
   output logic             inhibit_in,
   output logic [31:0]      cell_sense,
   output logic             meas_valid,
   output logic [4:0]       meas_ch,
   output logic [31:0]      meas_value,
   output logic             prot_trip
);
   initial begin
      inhibit_in = 1'h0;
      cell_sense = 32'h0;
      meas_valid = 1'h0;
      meas_ch    = 5'h0;
      meas_value = 32'h0;
      prot_trip  = 1'h0;
   end
   task automatic pins(input logic inhibit_latched_flag, input logic [31:0] cells);
      @(posedge sys_clk);
      inhibit_in <= inhibit_latched_flag;
      cell_sense <= cells;
   endtask
   // stale data is inverted so a missed strobe cannot look like a fresh word
   task automatic meas(input logic [4:0] ch, input logic [31:0] v);
      @(posedge sys_clk);
      meas_valid <= 1'h1;
      meas_ch    <= ch;
      meas_value <= v;
      @(posedge sys_clk);
      meas_valid <= 1'h0;
      meas_ch    <= ~ch;
      meas_value <= ~v;
   endtask
   task automatic trip();
      @(posedge sys_clk);
      prot_trip <= 1'h1;
      @(posedge sys_clk);
      prot_trip <= 1'h0;
   endtask
endmodule

// ===== verification/ctci_top_test.sv
// Purpose: register-level test of session control, inhibit and indicators
// Assumes: SEC_CYC 10 and BLINK_CYC 4 to keep the run short
// Notes:   reads return data in the cycle after the strobe only
`timescale 1ns/1ps
module ctci_top_test;
   logic        sys_clk = 1'h0;
   logic        rst = 1'h1;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'h0;
   logic        rd = 1'h0;
   logic [31:0] rdata, cell_sense, meas_value, chan_connect, got;
   logic        inhibit_in, meas_valid, prot_trip, error_led, locate_led, l0;
   logic [4:0]  meas_ch;
   int          fail_count = 0;
   int          comparisons = 0;
   int          n, p, e;
   int          tl [16] = '{0, 1, 4, 5, 8, 9, 16, 17, 32, 33, 64, 65, 128, 129, 250, 256};
   logic [7:0]  ba [4] = '{ctci_pkg::A_OVP, ctci_pkg::A_UVP, ctci_pkg::A_OCP, ctci_pkg::A_TINT};
   logic [31:0] bv [4] = '{32'h1387, 32'hafc9, 32'hfffe795f, 32'h101};
   logic [31:0] gv [4] = '{32'hafc8, 32'h1388, 32'hfffe7960, 32'h100};

   always #5 sys_clk = ~sys_clk;

   ctci_top #(.SEC_CYC(10), .BLINK_CYC(4)) ctci_top_i (
      .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .inhibit_in(inhibit_in), .cell_sense(cell_sense),
      .meas_valid(meas_valid), .meas_ch(meas_ch), .meas_value(meas_value),
      .prot_trip(prot_trip), .chan_connect(chan_connect), .error_led(error_led),
      .locate_led(locate_led));

   ctci_far_model ctci_far_model_i (
      .sys_clk(sys_clk), .inhibit_in(inhibit_in), .cell_sense(cell_sense),
      .meas_valid(meas_valid), .meas_ch(meas_ch), .meas_value(meas_value),
      .prot_trip(prot_trip));

   task automatic report_and_stop();
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge sys_clk);
      wr    <= 1'h0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge sys_clk);
      rd   <= 1'h0;
      #1;
      got  = rdata;
   endtask
   // one bit wider than a word so an indicator can ride beside a channel mask
   task automatic chk(input logic [32:0] g, input logic [32:0] x);
      comparisons++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      rd_reg(a);
      chk(got, x);
   endtask
   task automatic wait_bit(input int b, input int lim);
      n = 0;
      do begin
         rd_reg(ctci_pkg::A_STAT);
         n++;
      end while (got[b] !== 1'h1 && n < lim);
      chk(got >> b & 32'h1, 32'h1);
      if (got[b] !== 1'h1) report_and_stop();
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic blinks(input int k);
      n = 0;
      l0 = locate_led;
      repeat (k) begin
         cyc(1);
         if (locate_led !== l0) n++;
         l0 = locate_led;
      end
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk);
      chk(32'h0, 32'h1);
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'h0;
      rchk(ctci_pkg::A_TINT, 32'h1);
      rchk(ctci_pkg::A_STAT, 32'h0);
      rchk(8'hfc, 32'h0);
      foreach (tl[i]) begin
         e = (tl[i] == 0) ? 1 : tl[i];
         for (p = 4; p < e; p = p * 2) ;
         wr_reg(ctci_pkg::A_TINT, 32'(tl[i]));
         rchk(ctci_pkg::A_TINT, 32'(e));
         rchk(ctci_pkg::A_UPD, 32'(p));
         rchk(ctci_pkg::A_MAXH, 32'(e * 24));
      end
      wr_reg(ctci_pkg::A_CHAN, 32'h8000_0001);
      foreach (ba[i]) begin
         wr_reg(ba[i], bv[i]);
         wr_reg(ctci_pkg::A_CTRL, 32'h1);
         rchk(ctci_pkg::A_STAT, 32'h80);
         wr_reg(ctci_pkg::A_CTRL, 32'h4);
         rchk(ctci_pkg::A_STAT, 32'h0);
         wr_reg(ba[i], gv[i]);
      end
      rchk(ctci_pkg::A_QOVP, 32'h0);
      wr_reg(ctci_pkg::A_CTRL, 32'h1);
      rchk(ctci_pkg::A_STAT, 32'h100);
      chk(chan_connect, 32'h8000_0001);
      wr_reg(ctci_pkg::A_QSEL, 32'h1f);
      rchk(ctci_pkg::A_QOVP, 32'hafc8);
      rchk(ctci_pkg::A_QUVP, 32'h1388);
      rchk(ctci_pkg::A_QOCP, 32'hfffe7960);
      rchk(ctci_pkg::A_QTINT, 32'h100);
      wr_reg(ctci_pkg::A_CTRL, 32'h2);
      rd_reg(ctci_pkg::A_STAT);
      chk(got & 32'h300, 32'h100);
      ctci_far_model_i.meas(5'h0, 32'h1234abcd);
      wr_reg(ctci_pkg::A_QSEL, 32'h0);
      rchk(ctci_pkg::A_RES, 32'h1234abcd);
      wr_reg(ctci_pkg::A_QSEL, 32'h5);
      rchk(ctci_pkg::A_RES, ctci_pkg::NAN_MARK);
      wait_bit(0, 2000);
      ctci_far_model_i.pins(1'h1, 32'h0);
      cyc(5);
      chk({error_led, chan_connect}, 33'h0_8000_0001);
      ctci_far_model_i.pins(1'h0, 32'h0);
      wr_reg(ctci_pkg::A_CFG, 32'h1);
      ctci_far_model_i.pins(1'h1, 32'h0);
      cyc(1);
      chk(chan_connect, 32'h8000_0001);
      cyc(3);
      chk({error_led, chan_connect}, 33'h1_0000_0000);
      ctci_far_model_i.pins(1'h0, 32'h0);
      cyc(4);
      chk({error_led, chan_connect}, 33'h1_8000_0001);
      wr_reg(ctci_pkg::A_CTRL, 32'h4);
      cyc(2);
      chk({31'h0, error_led}, 32'h0);
      wr_reg(ctci_pkg::A_CFG, 32'h2);
      ctci_far_model_i.pins(1'h1, 32'h0);
      cyc(4);
      ctci_far_model_i.pins(1'h0, 32'h0);
      ctci_far_model_i.trip();
      cyc(4);
      chk(chan_connect, 32'h0);
      rd_reg(ctci_pkg::A_STAT);
      chk(got & 32'h70, 32'h70);
      wr_reg(ctci_pkg::A_CTRL, 32'h4);
      rd_reg(ctci_pkg::A_STAT);
      chk(got & 32'hf8, 32'h0);
      chk({error_led, chan_connect}, 33'h0_8000_0001);
      wr_reg(ctci_pkg::A_CTRL, 32'h8);
      ctci_far_model_i.pins(1'h0, 32'h0000_00f0);
      wr_reg(ctci_pkg::A_TINT, 32'h1e);
      wr_reg(ctci_pkg::A_CFG, 32'h0);
      wr_reg(ctci_pkg::A_CHAN, 32'h0000_0ff0);
      wr_reg(ctci_pkg::A_CTRL, 32'h2);
      wait_bit(1, 20);
      chk(got & 32'h3, 32'h2);
      rchk(ctci_pkg::A_PRES, 32'h0000_00f0);
      wr_reg(ctci_pkg::A_CFG, 32'h4);
      blinks(40);
      chk(32'(n >= 9 && n <= 11), 32'h1);
      wr_reg(ctci_pkg::A_CFG, 32'h0);
      cyc(2);
      blinks(20);
      chk({locate_led, 31'(n)}, 32'h0);
      report_and_stop();
   end
endmodule
